// ### trpa_core.sv
// Operation
// [RL1] Table read loads latch, flags untouched
// [RL2] Low two opcode bits pick pointer update
// [RL3] Mode zero keeps pointer unchanged
// [RL4] Pre-increment bumps pointer before reading
// [RL5] Table read: two cycles, read in second
// [RL6] Latch written in final phase
// [RL7] Add 6-bit literal to selected pointer
// [RL8] Single-cycle writeback, no flags, E8 opcode
// [RL9] Add to pointer two, then return
// [RL10] Pointer bit zero picks byte of word
// [RL11] Return form: two cycles, selector three
`include "trpa_defines.svh"

module trpa_core #(
	parameter int PTR_W = `TRPA_PTR_W,
	parameter int IPTR_W = `TRPA_IPTR_W,
	parameter int LIT_W = `TRPA_LIT_W,
	parameter int NUM_IPTR = `TRPA_NUM_IPTR
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic instr_valid,
	input wire logic [15:0] opcode,
	output logic busy,
	output logic [PTR_W-1:0] pm_addr,
	output logic pm_rd,
	input wire logic [15:0] pm_word,
	output logic [7:0] table_latch,
	output logic [PTR_W-1:0] table_pointer,
	output logic [IPTR_W-1:0] indirect_pointer0,
	output logic [IPTR_W-1:0] indirect_pointer1,
	output logic [IPTR_W-1:0] indirect_pointer_two,
	input wire logic [PTR_W-1:0] return_stack_top,
	output logic pc_load,
	output logic [PTR_W-1:0] pc_value,
	output logic stack_pop
);
	// Decoded fields travel to the sequencer as one bundle
	trpa_dec_if dif();

	trpa_decode u_dec (
		.opcode(opcode),
		.d(dif.dec)
	);

	// Sequencer state
	trpa_pkg::trpa_state_t st_q, st_d;
	logic [1:0] ph_q, ph_d;
	logic [1:0] upd_q, upd_d;

	// Table path state
	logic [PTR_W-1:0] tp_q, tp_d;
	logic [7:0] lat_q, lat_d;

	// Return path state
	logic ld_q, ld_d;
	logic [PTR_W-1:0] pcv_q, pcv_d;

	// Slot strobes, one per instruction form
	logic last_ph;
	logic take;
	logic take_tread;
	logic take_addlit;
	logic take_ret;

	// Shared by the normal and the return form of the pointer add
	function automatic logic sel_hits(input logic [1:0] sel, input int idx);
		sel_hits = (int'(sel) == idx);
	endfunction

	// Literal is unsigned, so it is zero-extended before the add
	function automatic logic [IPTR_W-1:0] add_lit(input logic [IPTR_W-1:0] v, input logic [LIT_W-1:0] k);
		add_lit = v + IPTR_W'(k);
	endfunction

	// Instructions are accepted only in the last phase of an idle cycle
	always_comb begin
		last_ph = (ph_q == `TRPA_Q_LAST);
		take = instr_valid && last_ph && (st_q == trpa_pkg::TRPA_ST_IDLE);
		take_tread = take && dif.is_tread;
		take_addlit = take && dif.is_addlit;
		take_ret = take && dif.is_ret;
	end

	// Phase counter runs free: four clocks make one instruction cycle
	always_comb begin
		ph_d = ph_q + 2'h1;
		st_d = st_q;
		upd_d = upd_q;
		case (st_q)
			trpa_pkg::TRPA_ST_IDLE: begin
				if (take_tread) begin
					st_d = trpa_pkg::TRPA_ST_TBL2; // RL5
					upd_d = dif.upd; // RL2
				end else if (take_ret) begin
					st_d = trpa_pkg::TRPA_ST_RET2; // RL11
				end
			end
			trpa_pkg::TRPA_ST_TBL2: begin
				if (last_ph) begin
					st_d = trpa_pkg::TRPA_ST_IDLE; // RL5
				end
			end
			trpa_pkg::TRPA_ST_RET2: begin
				if (last_ph) begin
					st_d = trpa_pkg::TRPA_ST_IDLE; // RL11
				end
			end
			default: begin
				st_d = trpa_pkg::TRPA_ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			st_q <= trpa_pkg::TRPA_ST_IDLE;
			ph_q <= `TRPA_Q_FIRST;
			upd_q <= `TRPA_UPD_NONE;
		end else begin
			st_q <= st_d;
			ph_q <= ph_d;
			upd_q <= upd_d;
		end
	end

	// Pre-increment moves at the take edge so the read sees the new address
	always_comb begin
		tp_d = tp_q;
		if (take_tread && (dif.upd == `TRPA_UPD_PREINC)) begin
			tp_d = tp_q + PTR_W'(1); // RL4
		end else if ((st_q == trpa_pkg::TRPA_ST_TBL2) && last_ph) begin
			case (upd_q)
				`TRPA_UPD_POSTINC: tp_d = tp_q + PTR_W'(1); // RL2
				`TRPA_UPD_POSTDEC: tp_d = tp_q - PTR_W'(1); // RL2
				default: tp_d = tp_q; // RL3
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			tp_q <= '0;
		end else begin
			tp_q <= tp_d;
		end
	end

	always_comb begin
		lat_d = lat_q;
		if ((st_q == trpa_pkg::TRPA_ST_TBL2) && last_ph) begin
			// Memory has the whole cycle to settle; only the last phase is used
			lat_d = tp_q[0] ? pm_word[15:8] : pm_word[7:0]; // RL1 RL6 RL10
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			lat_q <= 8'h00;
		end else begin
			lat_q <= lat_d;
		end
	end

	// One word per selector value; selector three never reaches a word here
	generate
		for (genvar g = 0; g < NUM_IPTR; g++) begin : g_iptr
			logic [IPTR_W-1:0] val_q;
			logic [IPTR_W-1:0] val_d;

			always_comb begin
				val_d = val_q;
				if (take_addlit && sel_hits(dif.sel, g)) begin
					val_d = add_lit(val_q, dif.lit); // RL7 RL8
				end else if (take_ret && sel_hits(`TRPA_SEL_TWO, g)) begin
					val_d = add_lit(val_q, dif.lit); // RL9
				end
			end

			always_ff @(posedge clk or negedge rst_b) begin
				if (!rst_b) begin
					val_q <= '0;
				end else begin
					val_q <= val_d;
				end
			end
		end
	endgenerate

	// Return target is captured at the take edge; pc_load and stack_pop pulse in the first clock of the second, busy cycle
	always_comb begin
		ld_d = take_ret; // RL9
		pcv_d = pcv_q;
		if (take_ret) begin
			pcv_d = return_stack_top; // RL9
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ld_q <= 1'b0;
			pcv_q <= '0;
		end else begin
			ld_q <= ld_d;
			pcv_q <= pcv_d;
		end
	end

	// Status flags are never touched: this block has no flag outputs at all
	assign busy = (st_q != trpa_pkg::TRPA_ST_IDLE);
	assign pm_rd = (st_q == trpa_pkg::TRPA_ST_TBL2); // RL5
	assign pm_addr = tp_q;
	assign table_latch = lat_q;
	assign table_pointer = tp_q;
	assign indirect_pointer0 = g_iptr[0].val_q;
	assign indirect_pointer1 = g_iptr[1].val_q;
	assign indirect_pointer_two = g_iptr[2].val_q;
	assign pc_load = ld_q;
	assign stack_pop = ld_q;
	assign pc_value = pcv_q;
endmodule // trpa_core

// ### trpa_defines.svh
`ifndef TRPA_DEFINES_SVH
`define TRPA_DEFINES_SVH

`define TRPA_PTR_W 21
`define TRPA_IPTR_W 12
`define TRPA_NUM_IPTR 3
`define TRPA_LIT_W 6
`define TRPA_TREAD_HI 14'h0002
`define TRPA_ADDLIT_HI 8'hE8
`define TRPA_SEL_TWO 2'h2
`define TRPA_SEL_RET 2'h3
`define TRPA_UPD_NONE 2'h0
`define TRPA_UPD_POSTINC 2'h1
`define TRPA_UPD_POSTDEC 2'h2
`define TRPA_UPD_PREINC 2'h3
`define TRPA_Q_FIRST 2'h0
`define TRPA_Q_LAST 2'h3

`endif

// ### trpa_pkg.sv
`include "trpa_defines.svh"

package trpa_pkg;
	typedef enum logic [2:0] {
		TRPA_ST_IDLE = 3'h1,
		TRPA_ST_TBL2 = 3'h2,
		TRPA_ST_RET2 = 3'h4
	} trpa_state_t;
	typedef logic [`TRPA_PTR_W-1:0] trpa_ptr_t;
	typedef logic [`TRPA_IPTR_W-1:0] trpa_iptr_t;
endpackage

// ### trpa_dec_if.sv
`include "trpa_defines.svh"

interface trpa_dec_if;
	logic is_tread;
	logic is_addlit;
	logic is_ret;
	logic [1:0] upd;
	logic [1:0] sel;
	logic [`TRPA_LIT_W-1:0] lit;
	modport dec (output is_tread, output is_addlit, output is_ret, output upd, output sel, output lit);
	modport use_side (input is_tread, input is_addlit, input is_ret, input upd, input sel, input lit);
endinterface

// ### trpa_decode.sv
`include "trpa_defines.svh"

module trpa_decode (
	input wire logic [15:0] opcode,
	trpa_dec_if.dec d
);
	always_comb begin
		d.is_tread = (opcode[15:2] == `TRPA_TREAD_HI);
		d.is_addlit = (opcode[15:8] == `TRPA_ADDLIT_HI) && (opcode[7:6] != `TRPA_SEL_RET);
		d.is_ret = (opcode[15:8] == `TRPA_ADDLIT_HI) && (opcode[7:6] == `TRPA_SEL_RET);
		d.upd = opcode[1:0];
		d.sel = opcode[7:6];
		d.lit = opcode[5:0];
	end
endmodule // trpa_decode

// ### trpa_monitor.sv
module trpa_monitor (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [15:0] opcode,
	input wire logic busy,
	input wire logic pm_rd,
	input wire logic [7:0] table_latch,
	input wire logic [20:0] table_pointer,
	input wire logic [11:0] indirect_pointer_two,
	input wire logic [20:0] return_stack_top,
	input wire logic pc_load,
	input wire logic [20:0] pc_value,
	input wire logic stack_pop
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	sequence s_slot;
		busy [*4] ##1 !busy;
	endsequence
	a_busy_span: assert property ($rose(busy) |-> s_slot) else $error("busy span");
	a_rd_busy: assert property (pm_rd |-> busy) else $error("read idle");
	a_ptr_held: assert property (pm_rd && $past(pm_rd) |-> $stable(table_pointer)) else $error("ptr moved");
	a_latch_end: assert property ($changed(table_latch) |-> $fell(pm_rd)) else $error("latch early");
	a_pop_pair: assert property (pc_load == stack_pop) else $error("pop");
	a_load_pulse: assert property (pc_load |=> !pc_load) else $error("pulse");
	a_pc_top: assert property (pc_load |-> pc_value == $past(return_stack_top) && busy) else $error("pc");
	a_ret_sum: assert property (pc_load |-> indirect_pointer_two == $past(indirect_pointer_two) + $past(opcode[5:0]))
		else $error("sum");
endmodule // trpa_monitor
bind trpa_core trpa_monitor trpa_monitor_i (.*);

// ### tb_top.sv
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'h0, rst_b = 1'h0, instr_valid = 1'h0, busy;
	logic [15:0] opcode = 16'h0, pm_word = 16'h0;
	logic [7:0] table_latch;
	logic [20:0] table_pointer, return_stack_top = 21'h0;
	logic [11:0] p0, p1, p2;
	logic pm_rd, pc_load, stack_pop;
	logic [20:0] pm_addr, pc_value;
	logic [1:0] ph = 2'h0;
	int err_count = 0, samples_checked = 0;
	trpa_core trpa_core_i (.*, .indirect_pointer0(p0), .indirect_pointer1(p1), .indirect_pointer_two(p2));
	initial forever #25 clk = ~clk;
	// Mirrors the free-running phase so requests land in the sampling slot
	always @(posedge clk or negedge rst_b) ph <= rst_b ? ph + 2'h1 : 2'h0;
	task chk(input string n, input logic [28:0] e, g);
		samples_checked++;
		if (g !== e) begin
			err_count++;
			$display("MISMATCH %s exp %h got %h", n, e, g);
		end
	endtask
	task issue(input logic [15:0] op);
		@(negedge clk);
		while (ph != 2'h3 || busy) @(negedge clk);
		opcode = op;
		instr_valid = 1'h1;
		@(negedge clk);
		instr_valid = 1'h0;
	endtask
	task tbl(input logic [1:0] m, input logic [15:0] w, input logic [20:0] ea, input logic [7:0] el,
		input logic [20:0] ep);
		pm_word = w;
		issue({14'h0002, m});
		chk("rd_addr", {7'h00, 1'h1, ea}, {7'h00, pm_rd, pm_addr});
		repeat (4) @(negedge clk);
		chk("latch_ptr", {el, ep}, {table_latch, table_pointer});
		chk("rd_end", 29'h0, {28'h0, pm_rd});
	endtask
	task add_lit;
		issue(16'hE83F);
		issue(16'hE845);
		chk("ptrs", 29'h003F005, {5'h0, p0, p1});
		issue(16'hE8A3);
		chk("ptr_two", 29'h23, {17'h0, p2});
		chk("addlit_busy", 29'h0, {28'h0, busy});
	endtask
	task ret;
		return_stack_top = 21'h1ABCDE;
		issue(16'hE8C4);
		chk("ret_pc", {5'h0, 3'h7, 21'h1ABCDE}, {5'h0, pc_load, stack_pop, busy, pc_value});
		chk("ret_ptr2", 29'h27, {17'h0, p2});
		@(negedge clk);
		chk("ret_pulse", 29'h1, {27'h0, pc_load, busy});
		repeat (3) @(negedge clk);
		chk("ret_done", 29'h0, {28'h0, busy});
	endtask
	task summarize;
		if (err_count == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial begin
		repeat (6) @(negedge clk);
		rst_b = 1'h1;
		tbl(2'h0, 16'hA512, 21'h0, 8'h12, 21'h0);
		tbl(2'h3, 16'hA512, 21'h1, 8'hA5, 21'h1);
		tbl(2'h1, 16'h7C5E, 21'h1, 8'h7C, 21'h2);
		tbl(2'h2, 16'h3B96, 21'h2, 8'h96, 21'h1);
		add_lit;
		ret;
		summarize;
	end
	initial begin
		#20000;
		err_count++;
		summarize;
	end
endmodule // tb_top
